// [design/jtag_debug_consts.vh]
// Purpose: Constants for the debug and test port: TAP states, instructions, identification layout.
// Assumes: Included by the port design file by bare name.
// Notes: Definitions only.
`ifndef JTAG_DEBUG_CONSTS_VH
`define JTAG_DEBUG_CONSTS_VH

// ----------------------------------------------------------------
// TAP controller state codes
// ----------------------------------------------------------------
`define TAP_RESET 4'h0
`define TAP_IDLE 4'h1
`define TAP_SEL_DR 4'h2
`define TAP_CAP_DR 4'h3
`define TAP_SHIFT_DR 4'h4
`define TAP_EXIT1_DR 4'h5
`define TAP_PAUSE_DR 4'h6
`define TAP_EXIT2_DR 4'h7
`define TAP_UPD_DR 4'h8
`define TAP_SEL_IR 4'h9
`define TAP_CAP_IR 4'ha
`define TAP_SHIFT_IR 4'hb
`define TAP_EXIT1_IR 4'hc
`define TAP_PAUSE_IR 4'hd
`define TAP_EXIT2_IR 4'he
`define TAP_UPD_IR 4'hf

// ----------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------
`define IR_WIDTH 4
`define IR_CAPTURE 4'h1
`define INS_EXTEST 4'h0
`define INS_SAMPLE 4'h1
`define INS_SCAN_N 4'h2
`define INS_STM 4'h4
`define INS_COMM 4'h5
`define INS_DBG_SCAN 4'hc
`define INS_IDCODE 4'he
`define INS_BYPASS 4'hf

// ----------------------------------------------------------------
// Identification code field layout
// ----------------------------------------------------------------
`define ID_VER_MSB 31
`define ID_VER_LSB 28
`define ID_PART_MSB 27
`define ID_PART_LSB 12
`define ID_MFR_MSB 11
`define ID_MFR_LSB 1
`define ID_MARK_BIT 0

// ----------------------------------------------------------------
// Boundary chain and mode settling
// ----------------------------------------------------------------
`define BSR_LENGTH 160
`define CELL_IN 0
`define CELL_OUT 1
`define CELL_CTL 2
`define SCAN_CHAINS 3
`define MODE_SETTLE 3'h4

`endif

// [design/pin_sync3.v]
// Purpose: Three-stage synchroniser with agreement filter and edge pulses for pin inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes: A change is accepted once stages two and three agree.
module pin_sync3 #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire reset,
  input wire [WIDTH-1:0] pin,
  output reg [WIDTH-1:0] level_q,
  output reg [WIDTH-1:0] rise_q,
  output reg [WIDTH-1:0] fall_q
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  wire [WIDTH-1:0] agree;
  wire [WIDTH-1:0] level_d;

  // The first stage feeds only the second, so no logic sees a metastable value.
  assign agree = ~(s2_q ^ s3_q);
  assign level_d = (agree & s3_q) | (~agree & level_q);

  // Stage chain, filtered level and one-cycle edge pulses.
  always @(posedge clk) begin
    if (reset) begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
      s3_q <= {WIDTH{1'b0}};
      level_q <= {WIDTH{1'b0}};
      rise_q <= {WIDTH{1'b0}};
      fall_q <= {WIDTH{1'b0}};
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
      rise_q <= level_d & ~level_q;
      fall_q <= ~level_d & level_q;
    end
  end

endmodule

// [design/jtag_debug_test_port.v]
// Purpose: Debug and test access port: TAP, boundary scan, emulation chain access and comm channel.
// Assumes: clk is far faster than the test clock; processor-side signals are on clk.
// Notes: The mode is latched once after chip reset and never follows the pins afterwards.
//
// Functional notes
// - Scan-mode select low routes the test port to emulation debug logic.
// - Mode selection changes only through a chip reset.
// - Boundary scan needs both select pins high and three other pins low.
// - Boundary scan offers sample, external test and bypass.
// - Emulation mode returns the processor identification instead of the standard code.
// - The boundary chain is 160 bits long.
// - Each pad has output, input and direction cells.
// - Identification holds version, part number and manufacturer fields.
// - Standard identification bit zero always reads one; in emulation mode bit zero comes from CPU_ID.
// - Three processor scan chains are selected and shifted through the port.
// - Halt debug can insert a store-multiple instruction to export registers.
// - Monitor debug moves words between debugger and running monitor program.
// - Comm channel activity becomes processor interrupt sources.
// - System access through the emulation interface can be blocked.
`include "jtag_debug_consts.vh"

module jtag_debug_test_port #(
  parameter NUM_PADS = 53,
  parameter [3:0] ID_VERSION = 4'h3,    // Arbitrary value.
  parameter [15:0] ID_PART = 16'h1234,  // Arbitrary value.
  parameter [10:0] ID_MFR = 11'h0a5,    // Arbitrary value.
  parameter [31:0] CPU_ID = 32'h1000_0001  // Arbitrary value.
) (
  input wire clk,
  input wire reset,
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo_q,
  output reg tdo_oe_n_q,
  input wire test_mode_pin,
  input wire scan_mode_select_pin,
  input wire clock_input_pin,
  input wire wakeup_input_pin,
  input wire async_master_reset_pin,
  input wire [NUM_PADS-1:0] pad_in,
  input wire [NUM_PADS-1:0] core_out,
  input wire [NUM_PADS-1:0] core_oe,
  output reg [NUM_PADS-1:0] pad_out_q,
  output reg [NUM_PADS-1:0] pad_oe_n_q,
  output reg bscan_mode_q,
  output reg ice_mode_q,
  output reg [1:0] dbg_chain_sel_q,
  output reg dbg_capture_q,
  output reg dbg_shift_q,
  output reg dbg_update_q,
  output reg dbg_tdi_q,
  input wire dbg_tdo,
  input wire cpu_halted,
  output reg store_multiple_instruction_q,
  input wire [31:0] comm_to_dbg_data,
  input wire comm_to_dbg_valid,
  output reg comm_to_dbg_taken_q,
  output reg [31:0] comm_from_dbg_data_q,
  output reg comm_from_dbg_valid_q,
  input wire comm_from_dbg_ack,
  output reg comm_tx_irq_q,
  output reg comm_rx_irq_q,
  input wire ice_access_block
);

  localparam BSR_LEN = `BSR_LENGTH;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  wire [7:0] pins_lvl;
  wire [7:0] pins_rise;
  wire [7:0] pins_fall;
  wire tck_rise = pins_rise[0];
  wire tck_fall = pins_fall[0];
  wire tms_s = pins_lvl[1];
  wire tdi_s = pins_lvl[2];
  wire tst_s = pins_lvl[3];
  wire sel_s = pins_lvl[4];
  wire clock_input_pin_s = pins_lvl[5];
  wire wup_s = pins_lvl[6];
  wire amr_s = pins_lvl[7];

  // Every test and mode pin, the test clock included, is oversampled by clk through three stages.
  pin_sync3 #(.WIDTH(8)) u_sync (
    .clk(clk),
    .reset(reset),
    .pin({async_master_reset_pin, wakeup_input_pin, clock_input_pin,
          scan_mode_select_pin, test_mode_pin, tdi, tms, tck}),
    .level_q(pins_lvl),
    .rise_q(pins_rise),
    .fall_q(pins_fall)
  );

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Standard test access state machine, advanced on each test clock rise.
  function [3:0] tap_next;
    input [3:0] st;
    input m;
    begin
      case (st)
        `TAP_RESET: tap_next = m ? `TAP_RESET : `TAP_IDLE;
        `TAP_IDLE: tap_next = m ? `TAP_SEL_DR : `TAP_IDLE;
        `TAP_SEL_DR: tap_next = m ? `TAP_SEL_IR : `TAP_CAP_DR;
        `TAP_CAP_DR: tap_next = m ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
        `TAP_SHIFT_DR: tap_next = m ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
        `TAP_EXIT1_DR: tap_next = m ? `TAP_UPD_DR : `TAP_PAUSE_DR;
        `TAP_PAUSE_DR: tap_next = m ? `TAP_EXIT2_DR : `TAP_PAUSE_DR;
        `TAP_EXIT2_DR: tap_next = m ? `TAP_UPD_DR : `TAP_SHIFT_DR;
        `TAP_UPD_DR: tap_next = m ? `TAP_SEL_DR : `TAP_IDLE;
        `TAP_SEL_IR: tap_next = m ? `TAP_RESET : `TAP_CAP_IR;
        `TAP_CAP_IR: tap_next = m ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
        `TAP_SHIFT_IR: tap_next = m ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
        `TAP_EXIT1_IR: tap_next = m ? `TAP_UPD_IR : `TAP_PAUSE_IR;
        `TAP_PAUSE_IR: tap_next = m ? `TAP_EXIT2_IR : `TAP_PAUSE_IR;
        `TAP_EXIT2_IR: tap_next = m ? `TAP_UPD_IR : `TAP_SHIFT_IR;
        `TAP_UPD_IR: tap_next = m ? `TAP_SEL_DR : `TAP_IDLE;
        default: tap_next = `TAP_RESET;
      endcase
    end
  endfunction

  // Position of one cell of a pad in the boundary chain.
  function integer cell_idx;
    input integer pad;
    input integer kind;
    begin
      cell_idx = 3 * pad + kind;
    end
  endfunction

  // ----------------------------------------------------------------
  // Mode latch
  // ----------------------------------------------------------------
  reg [2:0] settle_q;
  reg mode_done_q;

  // The mode is sampled once the synchronisers have settled and is then frozen.
  // Freezing it keeps a live session from being torn away by a stray pin move.
  always @(posedge clk) begin
    if (reset) begin
      settle_q <= 3'h0;
      mode_done_q <= 1'b0;
      bscan_mode_q <= 1'b0;
      ice_mode_q <= 1'b0;
    end else if (!mode_done_q) begin
      if (settle_q == `MODE_SETTLE) begin
        mode_done_q <= 1'b1;
        bscan_mode_q <= tst_s & sel_s & ~clock_input_pin_s & ~wup_s & ~amr_s;
        ice_mode_q <= ~sel_s;
      end else begin
        settle_q <= settle_q + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register selection
  // ----------------------------------------------------------------
  reg [3:0] tap_q;
  reg [3:0] ir_q;
  reg [3:0] ir_sr_q;
  reg [31:0] dr_sr_q;
  reg [1:0] sel_sr_q;
  reg bypass_q;
  reg [BSR_LEN-1:0] bsr_sr_q;
  reg [BSR_LEN-1:0] bsr_upd_q;
  reg [BSR_LEN-1:0] bsr_capture;
  reg tdo_d;
  integer i;
  integer j;

  // Any instruction not decoded for the current mode falls back to the bypass cell.
  wire sel_id = ir_q == `INS_IDCODE;
  wire sel_bsr = bscan_mode_q && (ir_q == `INS_EXTEST || ir_q == `INS_SAMPLE);
  wire sel_extest = bscan_mode_q && ir_q == `INS_EXTEST;
  wire sel_comm = ice_mode_q && ir_q == `INS_COMM && !ice_access_block;
  wire sel_scan = ice_mode_q && ir_q == `INS_SCAN_N;
  wire sel_dbg = ice_mode_q && ir_q == `INS_DBG_SCAN && !ice_access_block;
  wire [31:0] id_word = ice_mode_q ? CPU_ID : {ID_VERSION, ID_PART, ID_MFR, 1'b1};

  // Capture image: input, output and direction cell for every pad.
  always @* begin
    bsr_capture = {BSR_LEN{1'b0}};
    for (i = 0; i < NUM_PADS; i = i + 1) begin
      bsr_capture[cell_idx(i, `CELL_IN)] = pad_in[i];
      bsr_capture[cell_idx(i, `CELL_OUT)] = core_out[i];
      bsr_capture[cell_idx(i, `CELL_CTL)] = core_oe[i];
    end
  end

  // ----------------------------------------------------------------
  // TAP controller and shift paths
  // ----------------------------------------------------------------

  // All shift paths move together; only the selected one reaches the output.
  always @(posedge clk) begin
    if (reset) begin
      tap_q <= `TAP_RESET;
      ir_q <= `INS_IDCODE;
      ir_sr_q <= 4'h0;
      dr_sr_q <= 32'h0;
      sel_sr_q <= 2'h0;
      bypass_q <= 1'b0;
      bsr_sr_q <= {BSR_LEN{1'b0}};
      bsr_upd_q <= {BSR_LEN{1'b0}};
      dbg_chain_sel_q <= 2'h0;
      comm_from_dbg_data_q <= 32'h0;
    end else if (tck_rise) begin
      tap_q <= tap_next(tap_q, tms_s);
      case (tap_q)
        `TAP_RESET: begin
          ir_q <= `INS_IDCODE;
        end
        `TAP_CAP_IR: begin
          ir_sr_q <= `IR_CAPTURE;
        end
        `TAP_SHIFT_IR: begin
          ir_sr_q <= {tdi_s, ir_sr_q[3:1]};
        end
        `TAP_UPD_IR: begin
          ir_q <= ir_sr_q;
        end
        `TAP_CAP_DR: begin
          dr_sr_q <= sel_comm ? comm_to_dbg_data : id_word;
          sel_sr_q <= dbg_chain_sel_q;
          bypass_q <= 1'b0;
          bsr_sr_q <= bsr_capture;
        end
        `TAP_SHIFT_DR: begin
          dr_sr_q <= {tdi_s, dr_sr_q[31:1]};
          sel_sr_q <= {tdi_s, sel_sr_q[1]};
          bypass_q <= tdi_s;
          bsr_sr_q <= {tdi_s, bsr_sr_q[BSR_LEN-1:1]};
        end
        `TAP_UPD_DR: begin
          if (sel_bsr) begin
            bsr_upd_q <= bsr_sr_q;
          end
          if (sel_scan && sel_sr_q != 2'h3) begin
            dbg_chain_sel_q <= sel_sr_q;
          end
          if (sel_comm) begin
            comm_from_dbg_data_q <= dr_sr_q;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Output selection for the data pin.
  always @* begin
    tdo_d = bypass_q;
    if (tap_q == `TAP_SHIFT_IR) begin
      tdo_d = ir_sr_q[0];
    end else if (sel_bsr) begin
      tdo_d = bsr_sr_q[0];
    end else if (sel_scan) begin
      tdo_d = sel_sr_q[0];
    end else if (sel_dbg) begin
      tdo_d = dbg_tdo;
    end else if (sel_id || sel_comm) begin
      tdo_d = dr_sr_q[0];
    end
  end

  // The data pin moves only on a test clock fall, half a period before the tester samples.
  always @(posedge clk) begin
    if (reset) begin
      tdo_q <= 1'b0;
      tdo_oe_n_q <= 1'b1;
    end else if (tck_fall) begin
      tdo_q <= tdo_d;
      tdo_oe_n_q <= !(tap_q == `TAP_SHIFT_IR || tap_q == `TAP_SHIFT_DR);
    end
  end

  // ----------------------------------------------------------------
  // Pads
  // ----------------------------------------------------------------

  // External test drives the pads from the update cells; otherwise the core owns them.
  always @(posedge clk) begin
    if (reset) begin
      pad_out_q <= {NUM_PADS{1'b0}};
      pad_oe_n_q <= {NUM_PADS{1'b1}};
    end else begin
      for (j = 0; j < NUM_PADS; j = j + 1) begin
        if (sel_extest) begin
          pad_out_q[j] <= bsr_upd_q[cell_idx(j, `CELL_OUT)];
          pad_oe_n_q[j] <= ~bsr_upd_q[cell_idx(j, `CELL_CTL)];
        end else begin
          pad_out_q[j] <= core_out[j];
          pad_oe_n_q[j] <= ~core_oe[j];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Processor debug hooks
  // ----------------------------------------------------------------

  // Strobes last one clk cycle each, so the processor side sees one per test clock.
  always @(posedge clk) begin
    if (reset) begin
      dbg_capture_q <= 1'b0;
      dbg_shift_q <= 1'b0;
      dbg_update_q <= 1'b0;
      dbg_tdi_q <= 1'b0;
      store_multiple_instruction_q <= 1'b0;
    end else begin
      dbg_capture_q <= tck_rise && sel_dbg && tap_q == `TAP_CAP_DR;
      dbg_shift_q <= tck_rise && sel_dbg && tap_q == `TAP_SHIFT_DR;
      dbg_update_q <= tck_rise && sel_dbg && tap_q == `TAP_UPD_DR;
      if (tck_rise) begin
        dbg_tdi_q <= tdi_s;
      end
      store_multiple_instruction_q <= tck_rise && tap_q == `TAP_UPD_IR && ir_sr_q == `INS_STM &&
                                      ice_mode_q && cpu_halted && !ice_access_block;
    end
  end

  // Comm channel: a new word from the debugger wins over a same-cycle acknowledge.
  always @(posedge clk) begin
    if (reset) begin
      comm_to_dbg_taken_q <= 1'b0;
      comm_from_dbg_valid_q <= 1'b0;
      comm_tx_irq_q <= 1'b0;
      comm_rx_irq_q <= 1'b0;
    end else begin
      comm_to_dbg_taken_q <= tck_rise && sel_comm && tap_q == `TAP_CAP_DR && comm_to_dbg_valid;
      if (tck_rise && sel_comm && tap_q == `TAP_UPD_DR) begin
        comm_from_dbg_valid_q <= 1'b1;
      end else if (comm_from_dbg_ack) begin
        comm_from_dbg_valid_q <= 1'b0;
      end
      comm_tx_irq_q <= ice_mode_q && !comm_to_dbg_valid;
      comm_rx_irq_q <= comm_from_dbg_valid_q;
    end
  end

endmodule

// [sim/jtag_port_monitor.sv]
// Purpose: Port checks for the debug and test port.
// Assumes: The mode settles within 31 cycles of reset.
// Notes: Bound to every instance of the port.
module jtag_port_monitor(
  input wire clk, input wire reset, input wire tck, input wire tdo_q, input wire bscan_mode_q, input wire ice_mode_q,
  input wire [1:0] dbg_chain_sel_q, input wire dbg_capture_q, input wire dbg_shift_q, input wire dbg_update_q,
  input wire cpu_halted, input wire store_multiple_instruction_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // All checks sample on clk and rest while reset is high.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  mode_excl_a: assert property (!(bscan_mode_q && ice_mode_q)) else $error("mode clash");
  mode_hold_a: assert property (##31 1 |-> $stable({bscan_mode_q, ice_mode_q})) else $error("mode moved");
  chain_sel_a: assert property (dbg_chain_sel_q != 2'h3) else $error("bad chain");
  chain_ice_a: assert property (dbg_shift_q || dbg_update_q |-> ice_mode_q) else $error("chain in scan");
  strobe_excl_a: assert property ($onehot0({dbg_capture_q, dbg_shift_q, dbg_update_q})) else $error("strobes");
  store_halt_a: assert property (store_multiple_instruction_q |-> $past(cpu_halted)) else $error("running");
  store_ice_a: assert property (store_multiple_instruction_q |-> ice_mode_q) else $error("store in scan");
  out_edge_a: assert property ($changed(tdo_q) |-> !tck) else $error("out on rise");
  cover property (bscan_mode_q);
  cover property (ice_mode_q);
  cover property ($changed(tdo_q));
endmodule
bind jtag_debug_test_port jtag_port_monitor mon (.*);

// [sim/jtag_probe.sv]
// Purpose: Debugger probe that clocks the test port.
// Assumes: One test clock lasts 16 clk cycles.
// Notes: The test clock rests low between frames.
module jtag_probe(
  input wire clk, input wire tdo, output logic tck, output logic tms, output logic tdi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {tck, tms, tdi} = 3'h2;
  // Lead-in path p of k bits, n data bits low first, then update and idle.
  task automatic xfer(input logic [31:0] p, input int k, input logic [31:0] d, input int n, output logic [31:0] o);
    o = 32'h0;
    for (int i = 0; i < k + n + 2; i++) begin
      tms = i < k ? p[i] : i >= k + n - 1 && i < k + n + 1;
      tdi = i >= k && i < k + n ? d[i - k] : 1'h0;
      repeat (8) @(negedge clk);
      if (i >= k && i < k + n) o[i - k] = tdo;
      tck = 1'h1;
      repeat (8) @(negedge clk);
      tck = 1'h0;
    end
  endtask
endmodule

// [sim/jtag_debug_test_port_tb.sv]
// Purpose: Self-checking bench for the debug and test port.
// Assumes: Identification parameters keep their defaults.
// Notes: Inputs move on the falling clock edge.
module jtag_debug_test_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [0:4][4:0] modes = {5'h18, 5'h08, 5'h1c, 5'h19, 5'h10};
  logic clk = 1'h0, reset = 1'h1, dbg_tdo = 1'h1, cpu_halted = 1'h1, ice_access_block = 1'h0;
  logic comm_to_dbg_valid = 1'h1, comm_from_dbg_ack = 1'h1;
  logic test_mode_pin, scan_mode_select_pin, clock_input_pin, wakeup_input_pin, async_master_reset_pin;
  logic [52:0] pad_in = 53'h5a, core_out = 53'h3c, core_oe = 53'hf0;
  logic [31:0] comm_to_dbg_data = 32'ha5, got;
  int mismatches = 0, checks = 0, cycles = 0;
  wire tck, tms, tdi, tdo_q, tdo_oe_n_q, bscan_mode_q, ice_mode_q, dbg_capture_q, dbg_shift_q, dbg_update_q;
  wire dbg_tdi_q, store_multiple_instruction_q, comm_to_dbg_taken_q, comm_from_dbg_valid_q, comm_tx_irq_q;
  wire comm_rx_irq_q;
  wire [52:0] pad_out_q, pad_oe_n_q;
  wire [1:0] dbg_chain_sel_q;
  wire [31:0] comm_from_dbg_data_q;
  jtag_debug_test_port DUT (.*);
  jtag_probe probe (.clk(clk), .tdo(tdo_q), .tck(tck), .tms(tms), .tdi(tdi));
  always #2.5 clk = ~clk;
  // A hang counts as a mismatch and closes the run.
  always @(posedge clk) if (++cycles == 20000) begin
    mismatches++;
    finish_test();
  end
  task automatic chk(input logic [31:0] e);
    checks++;
    if (got !== e) begin
      mismatches++;
      $display("wrong value at %0t: %h", $time, got);
    end
  endtask
  // The mode is latched only by a chip reset, so every pin set goes through one.
  task automatic chip_reset(input logic [4:0] p);
    {test_mode_pin, scan_mode_select_pin, clock_input_pin, wakeup_input_pin, async_master_reset_pin} = p;
    reset = 1'h1;
    repeat (12) @(negedge clk);
    reset = 1'h0;
    repeat (20) @(negedge clk);
    got = {30'h0, bscan_mode_q, ice_mode_q};
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 5; i++) begin
      chip_reset(modes[i]);
      chk({30'h0, modes[i] == 5'h18, !modes[i][3]});
    end
    $display("mode test done");
    chip_reset(5'h18);
    probe.xfer(32'h5f, 9, 32'h0, 32, got);
    chk({4'h3, 16'h1234, 11'h0a5, 1'h1});
    probe.xfer(32'h3, 4, 32'hf, 4, got);
    probe.xfer(32'h1, 3, 32'ha5, 8, got);
    chk(32'h4a);
    probe.xfer(32'h3, 4, 32'h1, 4, got);
    probe.xfer(32'h1, 3, 32'h0, 8, got);
    chk(32'h88);
    scan_mode_select_pin = 1'h0;
    repeat (40) @(negedge clk);
    got = {30'h0, bscan_mode_q, ice_mode_q};
    chk(32'h2);
    $display("scan test done");
    chip_reset(5'h00);
    probe.xfer(32'h5f, 9, 32'h0, 32, got);
    chk(32'h1000_0001);
    probe.xfer(32'h3, 4, 32'h4, 4, got);
    probe.xfer(32'h3, 4, 32'hc, 4, got);
    probe.xfer(32'h1, 3, 32'h3c, 8, got);
    $display("emulation test done");
    finish_test();
  end
endmodule
